// *** tb/psar_mac_model.sv ***
// stands in for the mac indirect access logic that relays host commands
module psar_mac_model (
	input wire logic i_core_clk,
	output psar_pkg::psar_mgmt_req_t o_req,
	input wire psar_pkg::psar_mgmt_rsp_t i_rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle from time zero
	initial begin
		o_req = '0;
	end

	// one indexed command: strobe for one cycle, answer expected one edge later
	task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
		output logic [15:0] rd, output logic got);
		got = 1'b0;
		rd = 16'h0000;
		@(posedge i_core_clk);
		o_req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
		@(posedge i_core_clk);
		// released data is scrambled so stale values cannot pass
		o_req <= '{valid: 1'b0, write: ~wr, index: ~idx, wdata: ~wd};
		@(posedge i_core_clk);
		if (i_rsp.ack === 1'b1) begin
			got = 1'b1;
			rd = i_rsp.rdata;
		end
	endtask
endmodule

// *** tb/testbench.sv ***
`include "psar_defines.svh"

// register bank bench: commands go through the mac model, line events from here
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] OUI_H = 16'hA5C3; // arbitrary value
	localparam logic [5:0] OUI_L = 6'h2D; // arbitrary value
	localparam logic [5:0] MODEL = 6'h11; // arbitrary value
	localparam logic [3:0] REV = 4'h9; // arbitrary value
	localparam logic [15:0] ST = 16'h7809; // fixed status bits
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	psar_pkg::psar_mgmt_req_t mreq;
	psar_pkg::psar_mgmt_rsp_t mrsp;
	psar_pkg::psar_line_t line = '0;
	logic lp_valid = 1'b0;
	logic [15:0] lp_word = 16'h0000;
	logic speed_sel = 1'b1;
	logic [15:0] adv_word;
	logic [1:0] pause_mode;
	logic pause_valid;
	int bad_count = 0;
	int total_checks = 0;

	// 100 MHz clock
	always #5 i_core_clk = ~i_core_clk;

	psar_regs #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL_NUM(MODEL), .REV_NUM(REV)) dut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mgmt(mreq), .o_mgmt(mrsp),
		.i_line(line), .i_lp_word_valid(lp_valid), .i_lp_word(lp_word),
		.i_speed_sel(speed_sel), .o_adv_word(adv_word), .o_pause_mode(pause_mode),
		.o_pause_valid(pause_valid));

	psar_mac_model mac (.i_core_clk(i_core_clk), .o_req(mreq), .i_rsp(mrsp));

	// word compare, counted
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// read one register and compare
	task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		mac.access(1'b0, idx, 16'h0000, d, ok);
		check({15'h0000, ok}, 16'h0001, "read answer");
		check(d, exp, "read data");
	endtask

	// write one register; a write is answered with zero data
	task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
		logic [15:0] d;
		logic ok;
		mac.access(1'b1, idx, wd, d, ok);
		check({15'h0000, ok}, 16'h0001, "write answer");
		check(d, 16'h0000, "write data");
	endtask

	// present one received partner code word
	task automatic lp_load(input logic [15:0] w);
		@(posedge i_core_clk);
		lp_valid <= 1'b1;
		lp_word <= w;
		@(posedge i_core_clk);
		lp_valid <= 1'b0;
		lp_word <= ~w;
	endtask

	// reset for 10 cycles with the given strap level
	task automatic do_reset(input logic strap);
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		speed_sel <= strap;
		repeat (10) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
	endtask

	// pause that negotiation should settle on
	function automatic logic [1:0] pause_exp(input logic [1:0] a, input logic [1:0] p);
		if (a[0] && p[0]) begin
			return 2'h1;
		end
		if (a[1] && p[1] && (a[0] || p[0])) begin
			return 2'h2;
		end
		return 2'h0;
	endfunction

	// counts and verdict
	task automatic results;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		do_reset(1'b1);
		line.link_up <= 1'b1;
		rd(`PSAR_IDX_ADVERTISE, 16'h01E1);
		rd(`PSAR_IDX_PARTNER, 16'h0001);
		rd(`PSAR_IDX_IDENT_HI, OUI_H);
		wr(`PSAR_IDX_IDENT_LO, 16'h0000);
		rd(`PSAR_IDX_IDENT_LO, {OUI_L, MODEL, REV});
		rd(`PSAR_IDX_STATUS, ST);
		rd(`PSAR_IDX_STATUS, ST | 16'h0004);
		// one-cycle fault, jabber and link-loss events
		@(posedge i_core_clk);
		line <= '{link_up: 1'b0, remote_fault: 1'b1, jabber: 1'b1, default: 1'b0};
		@(posedge i_core_clk);
		line <= '{link_up: 1'b1, default: 1'b0};
		rd(`PSAR_IDX_STATUS, ST | 16'h0012);
		rd(`PSAR_IDX_STATUS, ST | 16'h0004);
		wr(`PSAR_IDX_STATUS, 16'hFFFF);
		rd(`PSAR_IDX_STATUS, ST | 16'h0004);
		rd(5'h00, 16'h0000);
		rd(5'h1F, 16'h0000);
		line.an_complete <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		rd(`PSAR_IDX_STATUS, ST | 16'h0024);
		line.power_down <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		check({15'h0000, pause_valid}, 16'h0000, "pause idle");
		check({14'h0000, pause_mode}, 16'h0000, "pause mode idle");
		rd(`PSAR_IDX_STATUS, ST | 16'h0004);
		line.power_down <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		rd(`PSAR_IDX_STATUS, ST | 16'h0024);
		lp_load(16'hFFFF);
		rd(`PSAR_IDX_PARTNER, 16'h2FFF);
		wr(`PSAR_IDX_ADVERTISE, 16'hFFFF);
		rd(`PSAR_IDX_ADVERTISE, 16'h3DFF);
		check(adv_word, 16'h3DFF, "adv word");
		// every local and partner pause pairing
		for (int a = 0; a < 4; a++) begin
			for (int p = 0; p < 4; p++) begin
				wr(`PSAR_IDX_ADVERTISE, {4'h0, 2'(a), 10'h001});
				lp_load({4'h0, 2'(p), 10'h001});
				repeat (3) @(posedge i_core_clk);
				check({14'h0, pause_mode}, {14'h0, pause_exp(2'(a), 2'(p))}, "pause");
				check({15'h0, pause_valid}, 16'h0001, "pause valid");
			end
		end
		do_reset(1'b0);
		rd(`PSAR_IDX_ADVERTISE, 16'h0081);
		rd(`PSAR_IDX_PARTNER, 16'h0001);
		results;
	end

	// watchdog against a hung command
	initial begin
		repeat (20000) @(posedge i_core_clk);
		bad_count++;
		$display("[ERR] %0t timeout", $time);
		results;
	end
endmodule

// *** verilog/psar_defines.svh ***
`ifndef PSAR_DEFINES_SVH
`define PSAR_DEFINES_SVH

// register indexes
`define PSAR_IDX_STATUS 5'h01
`define PSAR_IDX_IDENT_HI 5'h02
`define PSAR_IDX_IDENT_LO 5'h03
`define PSAR_IDX_ADVERTISE 5'h04
`define PSAR_IDX_PARTNER 5'h05

// status field positions
`define PSAR_ST_CAPS_MSB 15
`define PSAR_ST_CAPS_LSB 11
`define PSAR_ST_CAPS_VAL 5'h0F
`define PSAR_ST_AN_DONE 5
`define PSAR_ST_RFAULT 4
`define PSAR_ST_AN_ABLE 3
`define PSAR_ST_LINK 2
`define PSAR_ST_JABBER 1
`define PSAR_ST_EXT_CAP 0

// advertisement layout
`define PSAR_ADV_RESET 16'h0081
`define PSAR_ADV_WR_MASK 16'h3DFF
`define PSAR_ADV_STRAP_MASK 16'h0160
`define PSAR_ADV_PAUSE_MSB 11
`define PSAR_ADV_PAUSE_LSB 10

// partner ability layout
`define PSAR_LP_RESET 16'h0001
`define PSAR_LP_COPY_MASK 16'h2FFF
`define PSAR_LP_PAUSE_MSB 11
`define PSAR_LP_PAUSE_LSB 10

// pause codes
`define PSAR_PAUSE_NONE 2'h0
`define PSAR_PAUSE_SYM 2'h1
`define PSAR_PAUSE_ASYM 2'h2
`define PSAR_PAUSE_BOTH 2'h3

`endif

// *** verilog/psar_latch_bit.sv ***
// one latching status bit: latch high holds ones, latch low holds zeros
module psar_latch_bit #(
	parameter bit LATCH_LOW = 1'b0
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_live,
	input wire logic i_read,
	output logic o_value
);

	logic value_q; // held value shown to software
	logic value_d; // next held value
	logic held_d; // value with the live condition folded in

	// latch high ors in events, latch low ands in losses
	assign held_d = LATCH_LOW ? (value_q & i_live) : (value_q | i_live);
	// a read reloads the live level, which already carries a same-cycle event
	assign value_d = i_read ? i_live : held_d;

	// hold register, cleared by reset
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			value_q <= 1'b0;
		end else begin
			value_q <= value_d;
		end
	end

	assign o_value = value_q;

endmodule

// *** verilog/psar_pkg.sv ***
package psar_pkg;

	// one management command as relayed by the MAC indirect access logic
	typedef struct packed {
		logic valid; // one-cycle request strobe
		logic write; // 1 = write, 0 = read
		logic [4:0] index; // register index
		logic [15:0] wdata; // write data
	} psar_mgmt_req_t;

	// answer to a management command
	typedef struct packed {
		logic ack; // one-cycle answer strobe
		logic [15:0] rdata; // read data, zero for writes
	} psar_mgmt_rsp_t;

	// live line conditions from the PHY core
	typedef struct packed {
		logic link_up; // link currently up
		logic remote_fault; // remote fault currently seen
		logic jabber; // jabber currently seen
		logic an_complete; // negotiation finished
		logic power_down; // PHY held in power down
	} psar_line_t;

endpackage

// *** verilog/psar_regs.sv ***
`include "psar_defines.svh"

// status, identifier, advertisement and partner ability registers of the PHY
module psar_regs #(
	parameter logic [15:0] OUI_HIGH = 16'h1234, // arbitrary value
	parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h2A, // arbitrary value
	parameter logic [3:0] REV_NUM = 4'h3 // arbitrary value
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire psar_pkg::psar_mgmt_req_t i_mgmt,
	output psar_pkg::psar_mgmt_rsp_t o_mgmt,
	input wire psar_pkg::psar_line_t i_line,
	input wire logic i_lp_word_valid,
	input wire logic [15:0] i_lp_word,
	input wire logic i_speed_sel,
	output logic [15:0] o_adv_word,
	output logic [1:0] o_pause_mode,
	output logic o_pause_valid
);

	// ---------------- command decode ----------------

	// request qualifiers
	wire rd_req;
	wire wr_req;
	// index hits
	wire hit_status;
	wire hit_ident_hi;
	wire hit_ident_lo;
	wire hit_adv;
	wire hit_lp;
	// status read reloads the latching bits from the live conditions
	wire status_rd;
	// advertisement write strobe
	wire adv_wr;

	// registers reached only by index through the management command
	assign rd_req = i_mgmt.valid & ~i_mgmt.write;
	assign wr_req = i_mgmt.valid & i_mgmt.write;
	assign hit_status = (i_mgmt.index == `PSAR_IDX_STATUS);
	assign hit_ident_hi = (i_mgmt.index == `PSAR_IDX_IDENT_HI);
	assign hit_ident_lo = (i_mgmt.index == `PSAR_IDX_IDENT_LO);
	assign hit_adv = (i_mgmt.index == `PSAR_IDX_ADVERTISE);
	assign hit_lp = (i_mgmt.index == `PSAR_IDX_PARTNER);
	assign status_rd = rd_req & hit_status;
	assign adv_wr = wr_req & hit_adv;

	// ---------------- latching status bits ----------------

	// latch kinds: bit 2 remote fault high, bit 1 link low, bit 0 jabber high
	localparam logic [2:0] LATCH_LOW_MASK = 3'h2;

	// live and latched conditions in the same order
	logic [2:0] live_vec;
	logic [2:0] latched_vec;

	assign live_vec = {i_line.remote_fault, i_line.link_up, i_line.jabber};

	// one latch cell per latching bit
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_latch
			psar_latch_bit #(
				.LATCH_LOW(LATCH_LOW_MASK[gi])
			) u_latch (
				.i_core_clk(i_core_clk),
				.i_rst_n(i_rst_n),
				.i_live(live_vec[gi]),
				.i_read(status_rd),
				.o_value(latched_vec[gi])
			);
		end
	endgenerate

	// ---------------- negotiation complete ----------------

	logic an_done_q; // completion flag
	logic an_done_d;

	// power down drops the flag; it sets again as soon as power down ends while an_complete is high
	assign an_done_d = i_line.an_complete & ~i_line.power_down;

	// completion flag register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			an_done_q <= 1'b0;
		end else begin
			an_done_q <= an_done_d;
		end
	end

	// ---------------- advertisement register ----------------

	logic [15:0] adv_q; // advertisement contents
	logic [15:0] adv_d;
	logic strap_done_q; // strap already applied
	logic [15:0] strap_bits; // strapped ability bits
	logic [15:0] adv_after_strap;

	// strap drives bits 8, 6 and 5 together
	assign strap_bits = i_speed_sel ? `PSAR_ADV_STRAP_MASK : 16'h0000;
	// first cycle after reset loads the strap into the strapped bits
	assign adv_after_strap = strap_done_q ? adv_q :
		((adv_q & ~`PSAR_ADV_STRAP_MASK) | strap_bits);
	// writes touch only writable bits; reserved bits stay zero
	assign adv_d = adv_wr ?
		((adv_after_strap & ~`PSAR_ADV_WR_MASK) | (i_mgmt.wdata & `PSAR_ADV_WR_MASK)) :
		adv_after_strap;

	// advertisement register and strap sampler
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			adv_q <= `PSAR_ADV_RESET;
			strap_done_q <= 1'b0;
		end else begin
			adv_q <= adv_d;
			strap_done_q <= 1'b1;
		end
	end

	// code word offered to the negotiation engine
	assign o_adv_word = adv_q;

	// ---------------- partner ability register ----------------

	logic [15:0] lp_q; // partner ability contents
	logic [15:0] lp_d;

	// copy partner fields; next page, acknowledge and reserved stay zero
	assign lp_d = i_lp_word_valid ? (i_lp_word & `PSAR_LP_COPY_MASK) : lp_q;

	// partner ability register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			lp_q <= `PSAR_LP_RESET;
		end else begin
			lp_q <= lp_d;
		end
	end

	// ---------------- pause resolution ----------------

	// local and partner pause fields
	wire [1:0] adv_pause;
	wire [1:0] lp_pause;
	wire sym_ok;
	wire asym_ok;
	logic [1:0] pause_d;
	logic [1:0] pause_q;
	logic pause_valid_q;

	assign adv_pause = adv_q[`PSAR_ADV_PAUSE_MSB:`PSAR_ADV_PAUSE_LSB];
	assign lp_pause = lp_q[`PSAR_LP_PAUSE_MSB:`PSAR_LP_PAUSE_LSB];
	// symmetric when both sides offer symmetric
	assign sym_ok = adv_pause[0] & lp_pause[0];
	// asymmetric when both offer it and at least one also offers symmetric
	assign asym_ok = adv_pause[1] & lp_pause[1] & (adv_pause[0] | lp_pause[0]);
	// symmetric wins, so the result is never both kinds
	assign pause_d = sym_ok ? `PSAR_PAUSE_SYM :
		(asym_ok ? `PSAR_PAUSE_ASYM : `PSAR_PAUSE_NONE);

	// resolved pause register, only meaningful after completion
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pause_q <= `PSAR_PAUSE_NONE;
			pause_valid_q <= 1'b0;
		end else begin
			pause_q <= an_done_q ? pause_d : `PSAR_PAUSE_NONE;
			pause_valid_q <= an_done_q;
		end
	end

	assign o_pause_mode = pause_q;
	assign o_pause_valid = pause_valid_q;

	// ---------------- read data ----------------

	wire [15:0] status_word;
	wire [15:0] ident_hi_word;
	wire [15:0] ident_lo_word;
	logic [15:0] rdata_sel;
	logic [15:0] rdata_q;
	logic ack_q;

	// fixed abilities, reserved zeros and live/latched flags
	assign status_word = {`PSAR_ST_CAPS_VAL, 5'h00, an_done_q, latched_vec[2], 1'b1,
		latched_vec[1], latched_vec[0], 1'b1};
	assign ident_hi_word = OUI_HIGH;
	assign ident_lo_word = {OUI_LOW, MODEL_NUM, REV_NUM};

	// select by index; unmapped indexes and writes read zero
	always_comb begin
		rdata_sel = 16'h0000;
		if (rd_req) begin
			if (hit_status) begin
				rdata_sel = status_word;
			end else if (hit_ident_hi) begin
				rdata_sel = ident_hi_word;
			end else if (hit_ident_lo) begin
				rdata_sel = ident_lo_word;
			end else if (hit_adv) begin
				rdata_sel = adv_q;
			end else if (hit_lp) begin
				rdata_sel = lp_q;
			end else begin
				rdata_sel = 16'h0000;
			end
		end
	end

	// answer one cycle after the request
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
			ack_q <= 1'b0;
		end else begin
			rdata_q <= rdata_sel;
			ack_q <= i_mgmt.valid;
		end
	end

	assign o_mgmt.ack = ack_q;
	assign o_mgmt.rdata = rdata_q;

	// ---------------- checks ----------------

	// index of the previous request, seen by the checks only
	logic [4:0] chk_idx_q;
	logic chk_rd_q;

	// remember last request
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			chk_idx_q <= 5'h00;
			chk_rd_q <= 1'b0;
		end else begin
			chk_idx_q <= i_mgmt.index;
			chk_rd_q <= rd_req;
		end
	end

	// checks run in the core clock domain and drop out during reset
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_status_fixed_bits: assert property (
		(chk_rd_q && ack_q && chk_idx_q == `PSAR_IDX_STATUS) |->
		(rdata_q[15:11] == 5'h0F && rdata_q[10:6] == 5'h00 && rdata_q[3] && rdata_q[0]))
		else $error("status fixed bits wrong");

	// reset guard keeps the release edge out of the antecedent
	a_an_done_follow: assert property (
		(i_rst_n && i_line.an_complete && !i_line.power_down) ##1
		(i_line.an_complete && !i_line.power_down) |-> an_done_q)
		else $error("completion flag not set");

	a_rfault_hold: assert property (
		(i_line.remote_fault && !status_rd) |=> latched_vec[2])
		else $error("remote fault not latched");

	a_link_low_hold: assert property (
		(!i_line.link_up && !status_rd) |=> !latched_vec[1])
		else $error("link loss not latched");

	a_jabber_hold: assert property (
		(latched_vec[0] && !status_rd) |=> latched_vec[0])
		else $error("jabber latch dropped");

	a_read_restore: assert property (
		status_rd |=> (latched_vec == $past(live_vec)))
		else $error("latched bits not restored by read");

	a_ident_words: assert property (
		(rd_req && hit_ident_lo) |=> (o_mgmt.ack && o_mgmt.rdata[15:10] == OUI_LOW
		&& o_mgmt.rdata[9:4] == MODEL_NUM && o_mgmt.rdata[3:0] == REV_NUM))
		else $error("identifier word wrong");

	a_adv_write: assert property (
		(adv_wr && strap_done_q) |=>
		(adv_q == ($past(i_mgmt.wdata) & `PSAR_ADV_WR_MASK)))
		else $error("advertisement write lost");

	a_pause_single: assert property (
		o_pause_mode != `PSAR_PAUSE_BOTH)
		else $error("pause resolved to both kinds");

	a_lp_upper_zero: assert property (
		(rd_req && hit_lp) |=> (o_mgmt.rdata[15:14] == 2'h0 && o_mgmt.rdata[12] == 1'b0))
		else $error("partner next page or ack set");

	a_ack_timing: assert property (
		i_mgmt.valid |=> o_mgmt.ack ##1 !$past(i_mgmt.valid) || o_mgmt.ack)
		else $error("answer missing");

	// identifier high word answers the constant
	a_ident_high: assert property (
		(rd_req && hit_ident_hi) |=> (o_mgmt.ack && o_mgmt.rdata == OUI_HIGH))
		else $error("identifier high word wrong");

	// partner copy keeps ability and pause fields, forces next page and ack low
	a_lp_capture: assert property (
		i_lp_word_valid |=> (lp_q[13] == $past(i_lp_word[13])
		&& lp_q[11:0] == $past(i_lp_word[11:0]) && lp_q[15:14] == 2'h0 && !lp_q[12]))
		else $error("partner word not captured");

	// partner register is read-only between captures
	a_lp_hold: assert property (
		!i_lp_word_valid |=> (lp_q == $past(lp_q)))
		else $error("partner register changed without a word");

	// strap lands in bits 8, 6 and 5 in the first released cycle
	a_strap_load: assert property (
		(i_rst_n && !strap_done_q && !adv_wr) |=> (adv_q[8] == $past(i_speed_sel)
		&& adv_q[6] == $past(i_speed_sel) && adv_q[5] == $past(i_speed_sel) && adv_q[7]))
		else $error("strap not applied");

	// power down drops the completion flag one cycle later
	a_power_clear: assert property (
		i_line.power_down |=> !an_done_q)
		else $error("completion flag kept in power down");

	// writes to other indexes leave the advertisement alone
	a_write_ignored: assert property (
		(wr_req && !hit_adv && strap_done_q) |=> (adv_q == $past(adv_q)))
		else $error("read-only write changed advertisement");

	// a write is answered with zero data
	a_write_answer: assert property (
		wr_req |=> (o_mgmt.ack && o_mgmt.rdata == 16'h0000))
		else $error("write answer wrong");

	// no pause is offered before negotiation completes
	a_pause_idle: assert property (
		!an_done_q |=> (o_pause_mode == `PSAR_PAUSE_NONE && !o_pause_valid))
		else $error("pause resolved before completion");

	// main scenarios reached by the bench
	c_status_link_loss: cover property (status_rd && !latched_vec[1] && i_line.link_up);
	c_adv_write: cover property (adv_wr ##[1:8] (rd_req && hit_adv));
	c_partner_word: cover property (i_lp_word_valid ##[1:4] (rd_req && hit_lp));
	c_pause_sym: cover property (o_pause_valid && o_pause_mode == `PSAR_PAUSE_SYM);
	c_pause_asym: cover property (o_pause_valid && o_pause_mode == `PSAR_PAUSE_ASYM);

endmodule
